// ===== rtl/direct_strobe_host_port.sv
// Operation
// - Single-strobe write with both byte enables low carries a 16-bit word.
// - Little-endian single enable writes low lane even byte or high lane odd.
// - Read strobe low returns word, or one lane per single low enable.
// - Big-endian swaps byte parity: low lane odd byte, high lane even byte.
// - Byte address bit ignored; only word address decoded, always aligned.
// - Wait mode: stall driven low after strobe falls, released after four clock cycles, before it rises.
// - No-wait read data valid by wait length plus 25 ns.
// - Split variant write starts on either write strobe falling.
// - Split variant strobes select lanes; read is always 16 bits.
module direct_strobe_host_port (
    input  wire logic                                clock_in,
    input  wire logic                                reset_n_in,
    input  wire logic                                split_strobe_mode_in,
    input  wire logic                                big_endian_in,
    input  wire logic                                wait_mode_in,
    input  wire logic                                chip_select_n_in,
    input  wire logic [host_port_pkg::ADDR_W-1:0]    addr_in,
    input  wire logic                                byte_addr_bit_in,
    input  wire logic                                space_select_in,
    input  wire logic                                write_strobe_n_in,
    input  wire logic                                upper_write_strobe_n_in,
    input  wire logic                                lower_write_strobe_n_in,
    input  wire logic                                read_strobe_n_in,
    input  wire logic                                upper_byte_en_n_in,
    input  wire logic                                lower_byte_en_n_in,
    input  wire logic [host_port_pkg::DATA_W-1:0]    data_in,
    output logic      [host_port_pkg::DATA_W-1:0]    data_out,
    output logic                                     data_oe_out,
    output logic                                     stall_n_out,
    output logic                                     stall_n_oe_out,
    output host_port_pkg::access_s                   access_out,
    output logic                                     access_valid_out,
    input  wire logic [host_port_pkg::DATA_W-1:0]    rdata_in
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------
    function automatic logic [1:0] lanes(input logic up_n, input logic lo_n);
        lanes = {~up_n, ~lo_n};
    endfunction : lanes

    // Lane swap for big-endian byte accesses; word accesses pass untouched
    function automatic logic [15:0] swap16(input logic [15:0] d, input logic be);
        swap16 = be ? {d[7:0], d[15:8]} : d;
    endfunction : swap16

    logic       wr_act;
    logic       rd_act;
    logic [1:0] lane_sel;

    always_comb begin
        if (split_strobe_mode_in) begin
            wr_act   = ~upper_write_strobe_n_in | ~lower_write_strobe_n_in;
            rd_act   = ~read_strobe_n_in & ~wr_act;
            lane_sel = wr_act ? lanes(upper_write_strobe_n_in, lower_write_strobe_n_in)
                              : 2'b11;
        end else begin
            wr_act   = ~write_strobe_n_in & read_strobe_n_in;
            rd_act   = ~read_strobe_n_in & write_strobe_n_in;
            lane_sel = lanes(upper_byte_en_n_in, lower_byte_en_n_in);
        end
        if (chip_select_n_in) begin
            wr_act = 1'b0;
            rd_act = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, STALL, DONE} state_e;

    state_e                            state_ff, nxt_state;
    logic [host_port_pkg::WAIT_W-1:0]  cnt_ff, nxt_cnt;
    logic                              is_wr_ff, nxt_is_wr;
    logic [host_port_pkg::DATA_W-1:0]  nxt_data;
    logic                              nxt_data_oe;
    logic                              nxt_stall_oe;
    host_port_pkg::access_s            nxt_access;
    logic                              nxt_access_valid;
    logic                              lane_swap;

    assign lane_swap = big_endian_in & (lane_sel != 2'b11);

    always_comb begin
        nxt_state        = state_ff;
        nxt_cnt          = cnt_ff;
        nxt_is_wr        = is_wr_ff;
        nxt_data         = data_out;
        nxt_data_oe      = 1'b0;
        nxt_stall_oe     = 1'b0;
        nxt_access       = access_out;
        nxt_access_valid = 1'b0;
        unique case (state_ff)
            IDLE: begin
                if (wr_act || rd_act) begin
                    nxt_state    = STALL;
                    nxt_cnt      = host_port_pkg::WAIT_RST;
                    nxt_is_wr    = wr_act;
                    nxt_stall_oe = wait_mode_in;
                    nxt_data_oe  = rd_act;
                    // Byte address bit deliberately unused; word aligned
                    nxt_access.word_addr = addr_in;
                    nxt_access.space_reg = space_select_in;
                    nxt_access.write     = wr_act;
                    nxt_access.lane_en   = lane_swap ? {lane_sel[0], lane_sel[1]}
                                                     : lane_sel;
                    nxt_access.wdata     = swap16(data_in, lane_swap);
                end
            end
            STALL: begin
                nxt_cnt      = cnt_ff + 8'h01;
                nxt_stall_oe = wait_mode_in;
                nxt_data_oe  = ~is_wr_ff;
                if (is_wr_ff)
                    nxt_access.wdata = swap16(data_in, lane_swap);
                if (cnt_ff == 8'(host_port_pkg::WAIT_LEN_CYC - 1)) begin
                    nxt_state        = DONE;
                    nxt_stall_oe     = 1'b0; // Released in the same cycle that data turns valid
                    nxt_access_valid = 1'b1;
                    nxt_data         = swap16(rdata_in, lane_swap);
                end
            end
            DONE: begin
                nxt_data_oe = ~is_wr_ff & (rd_act | ~chip_select_n_in & ~read_strobe_n_in);
                // Waits for the strobe to rise before the next access
                if (!wr_act && !rd_act) begin
                    nxt_state   = IDLE;
                    nxt_data_oe = 1'b0;
                end
            end
            default: nxt_state = IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff         <= IDLE;
            cnt_ff           <= host_port_pkg::WAIT_RST;
            is_wr_ff         <= 1'b0;
            data_out         <= host_port_pkg::DATA_RST;
            data_oe_out      <= 1'b0;
            stall_n_oe_out   <= 1'b0;
            access_out       <= '0;
            access_valid_out <= 1'b0;
        end else begin
            state_ff         <= nxt_state;
            cnt_ff           <= nxt_cnt;
            is_wr_ff         <= nxt_is_wr;
            data_out         <= nxt_data;
            data_oe_out      <= nxt_data_oe;
            stall_n_oe_out   <= nxt_stall_oe;
            access_out       <= nxt_access;
            access_valid_out <= nxt_access_valid;
        end
    end

    // Stall is only ever driven low; released by dropping enable
    always_ff @(posedge clock_in or negedge rst_n_ff) begin
        if (!rst_n_ff)
            stall_n_out <= 1'b0;
        else
            stall_n_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_stall_after_strobe;
        @(posedge clock_in) disable iff (!rst_n_ff)
        (state_ff == IDLE && (wr_act || rd_act) && wait_mode_in) |=> stall_n_oe_out;
    endproperty
    a_stall_after_strobe: assert property (p_stall_after_strobe)
        else $error("stall not driven after strobe");

    property p_stall_len;
        @(posedge clock_in) disable iff (!rst_n_ff)
        $rose(stall_n_oe_out) |-> stall_n_oe_out [*4] ##1 !stall_n_oe_out;
    endproperty
    a_stall_len: assert property (p_stall_len)
        else $error("stall length wrong");

    property p_no_cs_quiet;
        @(posedge clock_in) disable iff (!rst_n_ff)
        (state_ff == IDLE && chip_select_n_in) |=> !stall_n_oe_out && !data_oe_out;
    endproperty
    a_no_cs_quiet: assert property (p_no_cs_quiet)
        else $error("pins driven without select");

    property p_valid_after_wait;
        @(posedge clock_in) disable iff (!rst_n_ff)
        access_valid_out |-> $past(state_ff) == STALL && !stall_n_oe_out;
    endproperty
    a_valid_after_wait: assert property (p_valid_after_wait)
        else $error("access before stall release");

    property p_addr_latched;
        @(posedge clock_in) disable iff (!rst_n_ff)
        (state_ff == IDLE && (wr_act || rd_act)) |=> access_out.word_addr == $past(addr_in);
    endproperty
    a_addr_latched: assert property (p_addr_latched)
        else $error("word address not captured");

    property p_space;
        @(posedge clock_in) disable iff (!rst_n_ff)
        (state_ff == IDLE && (wr_act || rd_act))
            |=> access_out.space_reg == $past(space_select_in);
    endproperty
    a_space: assert property (p_space)
        else $error("space select lost");

    property p_split_read_word;
        @(posedge clock_in) disable iff (!rst_n_ff)
        (state_ff == IDLE && rd_act && split_strobe_mode_in) |=> access_out.lane_en == 2'b11;
    endproperty
    a_split_read_word: assert property (p_split_read_word)
        else $error("split read not word wide");

    property p_word_no_swap;
        @(posedge clock_in) disable iff (!rst_n_ff)
        (state_ff == IDLE && wr_act && lane_sel == 2'b11) |=> access_out.wdata == $past(data_in);
    endproperty
    a_word_no_swap: assert property (p_word_no_swap)
        else $error("word write altered");

    property p_be_swap;
        @(posedge clock_in) disable iff (!rst_n_ff)
        (state_ff == IDLE && wr_act && big_endian_in && lane_sel == 2'b01)
            |=> access_out.lane_en == 2'b10;
    endproperty
    a_be_swap: assert property (p_be_swap)
        else $error("big endian lane not swapped");
endmodule : direct_strobe_host_port

// ===== shared/host_port_pkg.sv
package host_port_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int WAIT_LEN_CYC    = 4;
    localparam int WRITE_EXTRA_CYC = 3;
    localparam int READ_EXTRA_NS   = 25;
    localparam int READ_EXTRA_CYC  = (READ_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [WAIT_W-1:0] WAIT_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              write;
        logic              space_reg;
        logic [ADDR_W-1:0] word_addr;
        logic [1:0]        lane_en;
        logic [DATA_W-1:0] wdata;
    } access_s;
endpackage : host_port_pkg

// ===== tb/host_model.sv
module host_model (
    input  wire logic        clock_in,
    input  wire logic        split_in,
    input  wire logic        wait_mode_in,
    input  wire logic        stall_n_in,
    input  wire logic [15:0] rd_bus_in,
    output logic             cs_n_out,
    output logic [17:0]      addr_out,
    output logic             byte_bit_out,
    output logic             space_out,
    output logic [3:0]       stb_n_out,
    output logic [1:0]       ben_n_out,
    output logic [15:0]      wd_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Idle bus
    // ------------------------------------------------------------
    // Called by the bench, so every pin has one driving process
    task automatic park();
        {cs_n_out, stb_n_out, ben_n_out} = 7'h7F;
        {addr_out, byte_bit_out, space_out, wd_out} = '0;
    endtask : park

    // ------------------------------------------------------------
    // One access, entered just after a clock edge
    // ------------------------------------------------------------
    task automatic xfer(input logic cs, input logic wr, input logic [1:0] ln,
                        input logic [17:0] a, input logic sp, input logic [15:0] wd,
                        output logic [15:0] rd);
        int n;
        int seen;
        n = 0;
        seen = 0;
        cs_n_out = !cs;
        addr_out = a;
        byte_bit_out = ~a[0];
        space_out = sp;
        wd_out = wd;
        ben_n_out = ~ln;
        stb_n_out = {!(wr && !split_in), !(wr && split_in && ln[1]),
                     !(wr && split_in && ln[0]), wr};
        if (wait_mode_in && cs) begin
            // Bounded so a silent device cannot hang the host
            while (n < 20 && !(seen > 0 && stall_n_in)) begin
                @(posedge clock_in);
                #1;
                n++;
                if (!stall_n_in) seen++;
            end
        end else begin
            repeat (host_port_pkg::WAIT_LEN_CYC + (wr ? host_port_pkg::WRITE_EXTRA_CYC
                    : host_port_pkg::READ_EXTRA_CYC)) @(posedge clock_in);
            #1;
        end
        rd = rd_bus_in;
        cs_n_out = 1'b1;
        stb_n_out = 4'hF;
        // Released bus never keeps the old value
        wd_out = ~wd;
        repeat (2) @(posedge clock_in);
        #1;
    endtask : xfer
endmodule : host_model

// ===== tb/tb_direct_strobe_host_port.sv
module tb_direct_strobe_host_port;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                    clock_in, reset_n, split, be, wm, cs_n, byte_bit, sp;
    logic                    data_oe_out, stall_n_out, stall_n_oe_out, access_valid_out;
    logic                    stall_line;
    logic [17:0]             addr;
    logic [3:0]              stb_n;
    logic [1:0]              ben_n;
    logic [15:0]             wd, rdata, data_out, rd_bus;
    host_port_pkg::access_s  access_out, last;
    logic [1:0]              ln_tab [3] = '{2'b11, 2'b01, 2'b10};
    int                      n_mismatch = 0, checks = 0, cyc = 0, n_acc = 0, n_stl = 0;
    int                      n_doe = 0;

    direct_strobe_host_port i_direct_strobe_host_port (
        .clock_in(clock_in), .reset_n_in(reset_n), .split_strobe_mode_in(split),
        .big_endian_in(be), .wait_mode_in(wm), .chip_select_n_in(cs_n), .addr_in(addr),
        .byte_addr_bit_in(byte_bit), .space_select_in(sp), .write_strobe_n_in(stb_n[3]),
        .upper_write_strobe_n_in(stb_n[2]), .lower_write_strobe_n_in(stb_n[1]),
        .read_strobe_n_in(stb_n[0]), .upper_byte_en_n_in(ben_n[1]),
        .lower_byte_en_n_in(ben_n[0]), .data_in(wd), .data_out(data_out),
        .data_oe_out(data_oe_out), .stall_n_out(stall_n_out), .stall_n_oe_out(stall_n_oe_out),
        .access_out(access_out), .access_valid_out(access_valid_out), .rdata_in(rdata));

    host_model i_host_model (
        .clock_in(clock_in), .split_in(split), .wait_mode_in(wm), .stall_n_in(stall_line),
        .rd_bus_in(rd_bus), .cs_n_out(cs_n), .addr_out(addr), .byte_bit_out(byte_bit),
        .space_out(sp), .stb_n_out(stb_n), .ben_n_out(ben_n), .wd_out(wd));

    // Stall line has a pull-up; an undriven data bus shows the inverse
    assign stall_line = stall_n_oe_out ? stall_n_out : 1'b1;
    assign rd_bus = data_oe_out ? data_out : ~data_out;

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // ------------------------------------------------------------
    // Monitor and timeout
    // ------------------------------------------------------------
    // Falling edge: outputs launched at the rising edge have settled
    always @(negedge clock_in) begin
        cyc++;
        if (access_valid_out === 1'b1) begin
            n_acc++;
            last = access_out;
        end
        // Pin level, so a wrong stall value is caught as well as its enable
        if (stall_line === 1'b0) n_stl++;
        if (data_oe_out === 1'b1) n_doe++;
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // One access with its expectations
    // ------------------------------------------------------------
    task automatic run(input logic cs, input logic wr, input logic [1:0] ln, input int i);
        logic [1:0]  hl, el;
        logic [15:0] src, ed, rd, m, wdv;
        logic [17:0] a;
        int          c_acc, c_stl, c_doe, exp_doe;
        hl = (split && !wr) ? 2'b11 : ln;
        el = (be && hl != 2'b11) ? {hl[0], hl[1]} : hl;
        wdv = 16'hC3A5 ^ (16'h0101 * 16'(i));
        rdata = ~wdv;
        src = wr ? wdv : rdata;
        ed = (be && hl != 2'b11) ? {src[7:0], src[15:8]} : src;
        m = wr ? {{8{el[1]}}, {8{el[0]}}} : {{8{hl[1]}}, {8{hl[0]}}};
        a = 18'h2_AAAA ^ 18'(i);
        c_acc = n_acc;
        c_stl = n_stl;
        c_doe = n_doe;
        i_host_model.xfer(cs, wr, ln, a, i[0], wdv, rd);
        // Read strobe is held low up to the edge at which the host takes the data
        exp_doe = wm ? host_port_pkg::WAIT_LEN_CYC + 1
                     : host_port_pkg::WAIT_LEN_CYC + host_port_pkg::READ_EXTRA_CYC;
        chk(n_acc - c_acc, {31'h0, cs});
        chk(n_stl - c_stl, (cs && wm) ? host_port_pkg::WAIT_LEN_CYC : 0);
        if (!cs) chk(n_doe - c_doe, 0);
        if (cs) begin
            chk(n_doe - c_doe, wr ? 0 : exp_doe);
            chk({last.write, last.space_reg, last.word_addr, last.lane_en},
                {wr, i[0], a, el});
            chk(wr ? (last.wdata & m) : (rd & m), ed & m);
        end
    endtask : run

    // Every endian, direction and lane pattern
    task automatic sweep(input logic s, input logic w);
        split = s;
        wm = w;
        for (int k = 0; k < 12; k++) begin
            be = k[0];
            run(1'b1, k[1], ln_tab[k / 4], k);
        end
    endtask : sweep

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_wait_single();
        sweep(1'b0, 1'b1);
        $display("test wait_single done");
    endtask : t_wait_single

    task automatic t_wait_split();
        sweep(1'b1, 1'b1);
        $display("test wait_split done");
    endtask : t_wait_split

    task automatic t_no_wait();
        sweep(1'b0, 1'b0);
        sweep(1'b1, 1'b0);
        $display("test no_wait done");
    endtask : t_no_wait

    task automatic t_no_select();
        wm = 1'b1;
        run(1'b0, 1'b1, 2'b11, 1);
        run(1'b0, 1'b0, 2'b01, 2);
        $display("test no_select done");
    endtask : t_no_select

    initial begin
        {split, be, wm, rdata} = '0;
        i_host_model.park();
        reset_n = 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        t_wait_single();
        t_wait_split();
        t_no_wait();
        t_no_select();
        results();
    end
endmodule : tb_direct_strobe_host_port
